// ### shared/pcd_defines.vh
// Purpose: constants for the port C / port D alternate function override block
// Assumes: 20 MHz system clock
// Notes:   bit positions of the pins that peripherals take over
`ifndef PCD_DEFINES_VH
`define PCD_DEFINES_VH

// port C pin positions
`define PCD_PC_OSC_OUT      7
`define PCD_PC_OSC_IN       6
`define PCD_PC_TEST_DIN     5
`define PCD_PC_TEST_DOUT    4
`define PCD_PC_TEST_MODE    3
`define PCD_PC_TEST_CLK     2
`define PCD_PC_SDA          1
`define PCD_PC_SCL          0

// port D pin positions
`define PCD_PD_T2_CMP       7
`define PCD_PD_T1_CAP       6
`define PCD_PD_T1_CMP_A     5
`define PCD_PD_T1_CMP_B     4
`define PCD_PD_IRQ_ONE      3
`define PCD_PD_IRQ_ZERO     2
`define PCD_PD_TX           1
`define PCD_PD_RX           0

// reset values
`define PCD_RST_OUT         8'h00
`define PCD_RST_OE_N        8'hFF
`define PCD_RST_PULLUP      8'h00
`define PCD_RST_SYNC        8'h00

// timing
`define PCD_CLK_PERIOD_NS   50
`define PCD_SPIKE_NS        50

`endif

// ### design/pcd_spike_filter.v
// Purpose: glitch filter for one two-wire line
// Assumes: input already synchronised to i_clk
// Notes:   output changes only after the input held a new level for CYCLES+1 samples
`timescale 1ns/100ps
`default_nettype none

module pcd_spike_filter #(
  parameter CYCLES = 1,
  parameter CW     = 4
) (
  input  wire i_clk,
  input  wire i_reset,
  input  wire i_in,
  output wire o_out
);

  reg          out_ff;
  reg [CW-1:0] cnt_ff;
  reg          nxt_out;
  reg [CW-1:0] nxt_cnt;

  always @* begin
    nxt_out = out_ff;
    nxt_cnt = {CW{1'b0}};
    if (i_in != out_ff) begin
      if (cnt_ff >= CYCLES[CW-1:0]) begin
        nxt_out = i_in;
      end else begin
        nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge i_clk) begin
    if (i_reset) begin
      // idle bus level is high
      out_ff <= 1'b1;
      cnt_ff <= {CW{1'b0}};
    end else begin
      out_ff <= nxt_out;
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_out = out_ff;

endmodule // pcd_spike_filter

`default_nettype wire

// ### design/pcd_alt_override.v
// Purpose: alternate function override for port C and port D pins
// Assumes: pin inputs are asynchronous; peripheral controls come from i_clk logic
// Notes:   pin outputs registered; oe_n low while the pin is driven
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defines.vh"

// Operation
// R01 - any asserted override enable replaces the port register contribution for that signal
// R02 - oscillator select frees port C bit 7: pull-up off, driver off, input off
// R03 - oscillator select frees port C bit 6: pull-up off, input disabled
// R04 - test access enabled keeps test data-in, mode and clock pull-ups on, even in reset
// R05 - test access: port C bit 5 carries test data in, driver and input off
// R06 - test access: port C bit 4 outputs test data, driven only while shifting
// R07 - test access: port C bit 3 feeds mode select, pull-up on, driver off
// R08 - test access: port C bit 2 is the test clock, no general I/O
// R09 - two-wire: port C bit 1 is data, value low, direction from data-out
// R10 - two-wire: port C bit 0 is clock, value low, direction from clock-out
// R11 - both two-wire inputs pass spike filters rejecting pulses under 50 ns
// R12 - two-wire pins keep pull-up from port data bit, gated by global disable
// R13 - two-wire enable switches on slew-rate limiting on its two pins
// R14 - software sets port D bit 7 direction; enabled compare output replaces value
// R15 - software sets port D bits 5,4 direction; compare A/B replace value
// R16 - port D bit 6 input goes to timer capture, no other override
// R17 - external interrupt enables force input enable on port D bits 3 and 2
// R18 - transmitter enable drives port D bit 1 as output with tx data, pull-up off
// R19 - receiver enable forces port D bit 0 input, pull-up follows data bit
module pcd_alt_override (
  input  wire       i_clk,
  input  wire       i_reset,
  // port registers
  input  wire [7:0] i_portc_data,
  input  wire [7:0] i_portc_dir,
  input  wire [7:0] i_portd_data,
  input  wire [7:0] i_portd_dir,
  input  wire       i_global_pullup_disable,
  // peripheral controls
  input  wire       i_async_timer_clock_sel,
  input  wire       i_test_access_enable,
  input  wire       i_instr_reg_shifting,
  input  wire       i_data_reg_shifting,
  input  wire       i_test_data_out,
  input  wire       i_two_wire_enable,
  input  wire       i_two_wire_sda_out,
  input  wire       i_two_wire_scl_out,
  input  wire       i_timer2_compare_en,
  input  wire       i_timer2_compare_out,
  input  wire       i_timer1_compare_a_en,
  input  wire       i_timer1_compare_a_out,
  input  wire       i_timer1_compare_b_en,
  input  wire       i_timer1_compare_b_out,
  input  wire       i_ext_irq_zero_en,
  input  wire       i_ext_irq_one_en,
  input  wire       i_serial_tx_enable,
  input  wire       i_serial_tx_data,
  input  wire       i_serial_rx_enable,
  // pins
  input  wire [7:0] i_portc_pin,
  input  wire [7:0] i_portd_pin,
  output wire [7:0] o_portc_pin_out,
  output wire [7:0] o_portc_pin_oe_n,
  output wire [7:0] o_portc_pullup,
  output wire [7:0] o_portd_pin_out,
  output wire [7:0] o_portd_pin_oe_n,
  output wire [7:0] o_portd_pullup,
  output wire       o_two_wire_slew_limit,
  // to port read path and peripherals
  output wire [7:0] o_portc_in,
  output wire [7:0] o_portd_in,
  output wire       o_timer_osc_active,
  output wire       o_test_data_in,
  output wire       o_test_mode_sel,
  output wire       o_test_clock,
  output wire       o_two_wire_sda_in,
  output wire       o_two_wire_scl_in,
  output wire       o_timer1_capture_in,
  output wire       o_ext_irq_zero_in,
  output wire       o_ext_irq_one_in,
  output wire       o_serial_rx_data
);

  localparam SPIKE_CYCLES = (`PCD_SPIKE_NS + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS;

  // override signals, port C
  reg  [7:0] c_pu_oe;
  reg  [7:0] c_pu_ov;
  reg  [7:0] c_dd_oe;
  reg  [7:0] c_dd_ov;
  reg  [7:0] c_pv_oe;
  reg  [7:0] c_pv_ov;
  reg  [7:0] c_die_oe;
  reg  [7:0] c_die_ov;
  // override signals, port D
  reg  [7:0] d_pu_oe;
  reg  [7:0] d_pu_ov;
  reg  [7:0] d_dd_oe;
  reg  [7:0] d_dd_ov;
  reg  [7:0] d_pv_oe;
  reg  [7:0] d_pv_ov;
  reg  [7:0] d_die_oe;
  reg  [7:0] d_die_ov;

  // resolved per-pin values
  wire [7:0] nxt_c_pullup;
  wire [7:0] nxt_c_dir;
  wire [7:0] nxt_c_out;
  wire [7:0] c_die;
  wire [7:0] nxt_d_pullup;
  wire [7:0] nxt_d_dir;
  wire [7:0] nxt_d_out;
  wire [7:0] d_die;

  reg  [7:0] c_out_ff;
  reg  [7:0] c_oe_n_ff;
  reg  [7:0] c_pullup_ff;
  reg  [7:0] d_out_ff;
  reg  [7:0] d_oe_n_ff;
  reg  [7:0] d_pullup_ff;
  reg        slew_ff;
  reg        osc_ff;

  // pin synchronisers
  reg  [7:0] c_meta_ff;
  reg  [7:0] c_sync_ff;
  reg  [7:0] d_meta_ff;
  reg  [7:0] d_sync_ff;
  reg  [7:0] c_in_ff;
  reg  [7:0] d_in_ff;
  reg  [2:0] test_in_ff;

  wire       sda_filt;
  wire       scl_filt;

  wire       pu_ok;
  assign pu_ok = ~i_global_pullup_disable;

  // port C override table
  always @* begin
    c_pu_oe  = 8'h00;
    c_pu_ov  = 8'h00;
    c_dd_oe  = 8'h00;
    c_dd_ov  = 8'h00;
    c_pv_oe  = 8'h00;
    c_pv_ov  = 8'h00;
    c_die_oe = 8'h00;
    c_die_ov = 8'h00;
    // R02 oscillator output pin
    c_pu_oe[`PCD_PC_OSC_OUT]  = i_async_timer_clock_sel;
    c_dd_oe[`PCD_PC_OSC_OUT]  = i_async_timer_clock_sel;
    c_die_oe[`PCD_PC_OSC_OUT] = i_async_timer_clock_sel;
    // R03 oscillator input pin
    c_pu_oe[`PCD_PC_OSC_IN]   = i_async_timer_clock_sel;
    c_dd_oe[`PCD_PC_OSC_IN]   = i_async_timer_clock_sel;
    c_die_oe[`PCD_PC_OSC_IN]  = i_async_timer_clock_sel;
    // R05 R04 test data in, pull-up on
    c_pu_oe[`PCD_PC_TEST_DIN]  = i_test_access_enable;
    c_pu_ov[`PCD_PC_TEST_DIN]  = 1'b1;
    c_dd_oe[`PCD_PC_TEST_DIN]  = i_test_access_enable;
    c_die_oe[`PCD_PC_TEST_DIN] = i_test_access_enable;
    // R06 test data out, driven while shifting
    c_pu_oe[`PCD_PC_TEST_DOUT]  = i_test_access_enable;
    c_dd_oe[`PCD_PC_TEST_DOUT]  = i_test_access_enable;
    c_dd_ov[`PCD_PC_TEST_DOUT]  = i_instr_reg_shifting | i_data_reg_shifting;
    c_pv_oe[`PCD_PC_TEST_DOUT]  = i_test_access_enable;
    c_pv_ov[`PCD_PC_TEST_DOUT]  = i_test_data_out;
    c_die_oe[`PCD_PC_TEST_DOUT] = i_test_access_enable;
    // R07 R04 mode select, pull-up on
    c_pu_oe[`PCD_PC_TEST_MODE]  = i_test_access_enable;
    c_pu_ov[`PCD_PC_TEST_MODE]  = 1'b1;
    c_dd_oe[`PCD_PC_TEST_MODE]  = i_test_access_enable;
    c_die_oe[`PCD_PC_TEST_MODE] = i_test_access_enable;
    // R08 R04 test clock, pull-up on
    c_pu_oe[`PCD_PC_TEST_CLK]  = i_test_access_enable;
    c_pu_ov[`PCD_PC_TEST_CLK]  = 1'b1;
    c_dd_oe[`PCD_PC_TEST_CLK]  = i_test_access_enable;
    c_die_oe[`PCD_PC_TEST_CLK] = i_test_access_enable;
    // R09 R12 data line, open drain
    c_pu_oe[`PCD_PC_SDA] = i_two_wire_enable;
    c_pu_ov[`PCD_PC_SDA] = i_portc_data[`PCD_PC_SDA] & pu_ok;
    c_dd_oe[`PCD_PC_SDA] = i_two_wire_enable;
    c_dd_ov[`PCD_PC_SDA] = i_two_wire_sda_out;
    c_pv_oe[`PCD_PC_SDA] = i_two_wire_enable;
    // R10 R12 clock line, open drain
    c_pu_oe[`PCD_PC_SCL] = i_two_wire_enable;
    c_pu_ov[`PCD_PC_SCL] = i_portc_data[`PCD_PC_SCL] & pu_ok;
    c_dd_oe[`PCD_PC_SCL] = i_two_wire_enable;
    c_dd_ov[`PCD_PC_SCL] = i_two_wire_scl_out;
    c_pv_oe[`PCD_PC_SCL] = i_two_wire_enable;
  end

  // port D override table
  always @* begin
    d_pu_oe  = 8'h00;
    d_pu_ov  = 8'h00;
    d_dd_oe  = 8'h00;
    d_dd_ov  = 8'h00;
    d_pv_oe  = 8'h00;
    d_pv_ov  = 8'h00;
    d_die_oe = 8'h00;
    d_die_ov = 8'h00;
    // R14 compare output, direction left to software
    d_pv_oe[`PCD_PD_T2_CMP]   = i_timer2_compare_en;
    d_pv_ov[`PCD_PD_T2_CMP]   = i_timer2_compare_out;
    // R15 compare A and B outputs
    d_pv_oe[`PCD_PD_T1_CMP_A] = i_timer1_compare_a_en;
    d_pv_ov[`PCD_PD_T1_CMP_A] = i_timer1_compare_a_out;
    d_pv_oe[`PCD_PD_T1_CMP_B] = i_timer1_compare_b_en;
    d_pv_ov[`PCD_PD_T1_CMP_B] = i_timer1_compare_b_out;
    // R17 interrupt inputs forced enabled
    d_die_oe[`PCD_PD_IRQ_ONE]  = i_ext_irq_one_en;
    d_die_ov[`PCD_PD_IRQ_ONE]  = 1'b1;
    d_die_oe[`PCD_PD_IRQ_ZERO] = i_ext_irq_zero_en;
    d_die_ov[`PCD_PD_IRQ_ZERO] = 1'b1;
    // R18 transmit pin forced output
    d_pu_oe[`PCD_PD_TX] = i_serial_tx_enable;
    d_dd_oe[`PCD_PD_TX] = i_serial_tx_enable;
    d_dd_ov[`PCD_PD_TX] = 1'b1;
    d_pv_oe[`PCD_PD_TX] = i_serial_tx_enable;
    d_pv_ov[`PCD_PD_TX] = i_serial_tx_data;
    // R19 receive pin forced input
    d_pu_oe[`PCD_PD_RX] = i_serial_rx_enable;
    d_pu_ov[`PCD_PD_RX] = i_portd_data[`PCD_PD_RX] & pu_ok;
    d_dd_oe[`PCD_PD_RX] = i_serial_rx_enable;
  end

  // R01 override muxes per pin
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      assign nxt_c_pullup[g] = c_pu_oe[g] ? c_pu_ov[g] : (i_portc_data[g] & ~i_portc_dir[g] & pu_ok);
      assign nxt_c_dir[g]    = c_dd_oe[g] ? c_dd_ov[g] : i_portc_dir[g];
      assign nxt_c_out[g]    = c_pv_oe[g] ? c_pv_ov[g] : i_portc_data[g];
      assign c_die[g]        = c_die_oe[g] ? c_die_ov[g] : 1'b1;
      assign nxt_d_pullup[g] = d_pu_oe[g] ? d_pu_ov[g] : (i_portd_data[g] & ~i_portd_dir[g] & pu_ok);
      assign nxt_d_dir[g]    = d_dd_oe[g] ? d_dd_ov[g] : i_portd_dir[g];
      assign nxt_d_out[g]    = d_pv_oe[g] ? d_pv_ov[g] : i_portd_data[g];
      assign d_die[g]        = d_die_oe[g] ? d_die_ov[g] : 1'b1;
    end
  endgenerate

  // pin drive registers
  always @(posedge i_clk) begin
    if (i_reset) begin
      c_out_ff    <= `PCD_RST_OUT;
      c_oe_n_ff   <= `PCD_RST_OE_N;
      d_out_ff    <= `PCD_RST_OUT;
      d_oe_n_ff   <= `PCD_RST_OE_N;
      d_pullup_ff <= `PCD_RST_PULLUP;
      slew_ff     <= 1'b0;
      osc_ff      <= 1'b0;
    end else begin
      c_out_ff    <= nxt_c_out;
      c_oe_n_ff   <= ~nxt_c_dir;
      d_out_ff    <= nxt_d_out;
      d_oe_n_ff   <= ~nxt_d_dir;
      d_pullup_ff <= nxt_d_pullup;
      // R13 slew limiting
      slew_ff     <= i_two_wire_enable;
      osc_ff      <= i_async_timer_clock_sel;
    end
  end

  // R04 test pull-ups held through reset
  always @(posedge i_clk) begin
    if (i_reset) begin
      c_pullup_ff                   <= `PCD_RST_PULLUP;
      c_pullup_ff[`PCD_PC_TEST_DIN]  <= i_test_access_enable;
      c_pullup_ff[`PCD_PC_TEST_MODE] <= i_test_access_enable;
      c_pullup_ff[`PCD_PC_TEST_CLK]  <= i_test_access_enable;
    end else begin
      c_pullup_ff <= nxt_c_pullup;
    end
  end

  // two-flop pin synchronisers
  always @(posedge i_clk) begin
    if (i_reset) begin
      c_meta_ff <= `PCD_RST_SYNC;
      c_sync_ff <= `PCD_RST_SYNC;
      d_meta_ff <= `PCD_RST_SYNC;
      d_sync_ff <= `PCD_RST_SYNC;
    end else begin
      c_meta_ff <= i_portc_pin;
      c_sync_ff <= c_meta_ff;
      d_meta_ff <= i_portd_pin;
      d_sync_ff <= d_meta_ff;
    end
  end

  // gated digital inputs and test-access pins
  always @(posedge i_clk) begin
    if (i_reset) begin
      c_in_ff    <= `PCD_RST_SYNC;
      d_in_ff    <= `PCD_RST_SYNC;
      test_in_ff <= 3'h0;
    end else begin
      c_in_ff    <= c_sync_ff & c_die;
      d_in_ff    <= d_sync_ff & d_die;
      // R05 R07 R08 test pins bypass the disabled input path
      test_in_ff <= {c_sync_ff[`PCD_PC_TEST_DIN], c_sync_ff[`PCD_PC_TEST_MODE], c_sync_ff[`PCD_PC_TEST_CLK]} &
                    {3{i_test_access_enable}};
    end
  end

  // R11 spike filters on both two-wire lines
  pcd_spike_filter #(
    .CYCLES (SPIKE_CYCLES),
    .CW     (4)
  ) u_sda_filt (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_in    (c_sync_ff[`PCD_PC_SDA]),
    .o_out   (sda_filt)
  );

  pcd_spike_filter #(
    .CYCLES (SPIKE_CYCLES),
    .CW     (4)
  ) u_scl_filt (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_in    (c_sync_ff[`PCD_PC_SCL]),
    .o_out   (scl_filt)
  );

  assign o_portc_pin_out       = c_out_ff;
  assign o_portc_pin_oe_n      = c_oe_n_ff;
  assign o_portc_pullup        = c_pullup_ff;
  assign o_portd_pin_out       = d_out_ff;
  assign o_portd_pin_oe_n      = d_oe_n_ff;
  assign o_portd_pullup        = d_pullup_ff;
  assign o_two_wire_slew_limit = slew_ff;
  assign o_timer_osc_active    = osc_ff;
  assign o_portc_in            = c_in_ff;
  assign o_portd_in            = d_in_ff;
  assign o_test_data_in        = test_in_ff[2];
  assign o_test_mode_sel       = test_in_ff[1];
  assign o_test_clock          = test_in_ff[0];
  assign o_two_wire_sda_in     = sda_filt;
  assign o_two_wire_scl_in     = scl_filt;
  // R16 capture input, no override
  assign o_timer1_capture_in   = d_in_ff[`PCD_PD_T1_CAP];
  // R17 interrupt inputs
  assign o_ext_irq_zero_in     = d_in_ff[`PCD_PD_IRQ_ZERO];
  assign o_ext_irq_one_in      = d_in_ff[`PCD_PD_IRQ_ONE];
  assign o_serial_rx_data      = d_in_ff[`PCD_PD_RX];

endmodule // pcd_alt_override

`default_nettype wire

// ### test/pcd_alt_override_asserts.sv
// Purpose: concurrent checks on the port C/D override block
// Assumes: bound to pcd_alt_override, one clock domain
// Notes:   pin-side timing guarded until the synchronisers settle
`timescale 1ns/100ps
`default_nettype none
module pcd_alt_override_asserts (
  input wire logic       i_clk, i_reset, i_global_pullup_disable, i_async_timer_clock_sel,
  input wire logic       i_test_access_enable, i_instr_reg_shifting, i_data_reg_shifting,
  input wire logic       i_test_data_out, i_two_wire_enable, i_two_wire_sda_out, i_two_wire_scl_out,
  input wire logic       i_timer2_compare_en, i_timer2_compare_out, i_serial_tx_enable,
  input wire logic       i_serial_tx_data, i_serial_rx_enable, o_two_wire_slew_limit,
  input wire logic       o_two_wire_scl_in, o_timer1_capture_in,
  input wire logic [7:0] i_portc_data, i_portd_data, i_portd_dir, i_portc_pin, i_portd_pin,
  input wire logic [7:0] o_portc_pin_out, o_portc_pin_oe_n, o_portc_pullup,
  input wire logic [7:0] o_portd_pin_out, o_portd_pin_oe_n, o_portd_pullup
);
  logic [3:0] settle_ff;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // cycles since reset, saturating
  always @(posedge i_clk) begin
    if (i_reset)
      settle_ff <= 4'h0;
    else if (settle_ff != 4'h8)
      settle_ff <= settle_ff + 4'h1;
  end
  sequence shift_req;
    i_test_access_enable && (i_instr_reg_shifting || i_data_reg_shifting);
  endsequence
  sequence tdo_idle;
    i_test_access_enable && !i_instr_reg_shifting && !i_data_reg_shifting;
  endsequence
  osc_pins_a: assert property (
    i_async_timer_clock_sel |=> o_portc_pin_oe_n[7:6] == 2'h3 && o_portc_pullup[7:6] == 2'h0)
    else $error("oscillator pins not released");
  test_pull_a: assert property (
    i_test_access_enable |=> o_portc_pullup[5] && o_portc_pullup[3] && o_portc_pullup[2]
      && !o_portc_pullup[4] && o_portc_pin_oe_n[5] && o_portc_pin_oe_n[3] && o_portc_pin_oe_n[2])
    else $error("test pins wrong");
  tdo_drive_a: assert property (
    shift_req |=> !o_portc_pin_oe_n[4] && o_portc_pin_out[4] == $past(i_test_data_out))
    else $error("test data out not driven");
  tdo_idle_a: assert property (
    tdo_idle |=> o_portc_pin_oe_n[4])
    else $error("test data out driven while idle");
  sda_line_a: assert property (
    i_two_wire_enable |=> o_portc_pin_oe_n[1] == !$past(i_two_wire_sda_out) && !o_portc_pin_out[1]
      && o_portc_pullup[1] == $past(i_portc_data[1] && !i_global_pullup_disable))
    else $error("data line wrong");
  scl_line_a: assert property (
    i_two_wire_enable |=> o_portc_pin_oe_n[0] == !$past(i_two_wire_scl_out) && !o_portc_pin_out[0])
    else $error("clock line wrong");
  slew_on_a: assert property (
    $changed(i_two_wire_enable) |=> o_two_wire_slew_limit == $past(i_two_wire_enable))
    else $error("slew limit wrong");
  scl_spike_a: assert property (
    settle_ff == 4'h8 && $changed(o_two_wire_scl_in) |->
      ($past(i_portc_pin[0], 2) == o_two_wire_scl_in && $past(i_portc_pin[0], 3) == o_two_wire_scl_in)
      || ($past(i_portc_pin[0], 3) == o_two_wire_scl_in && $past(i_portc_pin[0], 4) == o_two_wire_scl_in)
      || ($past(i_portc_pin[0], 4) == o_two_wire_scl_in && $past(i_portc_pin[0], 5) == o_two_wire_scl_in))
    else $error("clock filter passed a spike");
  t2_cmp_a: assert property (
    i_timer2_compare_en |=> o_portd_pin_out[7] == $past(i_timer2_compare_out)
      && o_portd_pin_oe_n[7] == !$past(i_portd_dir[7]))
    else $error("compare output wrong");
  tx_pin_a: assert property (
    i_serial_tx_enable |=> !o_portd_pin_oe_n[1] && o_portd_pin_out[1] == $past(i_serial_tx_data)
      && !o_portd_pullup[1])
    else $error("transmit pin wrong");
  rx_pin_a: assert property (
    i_serial_rx_enable |=> o_portd_pin_oe_n[0]
      && o_portd_pullup[0] == $past(i_portd_data[0] && !i_global_pullup_disable))
    else $error("receive pin wrong");
  cap_route_a: assert property (
    settle_ff == 4'h8 |-> o_timer1_capture_in == $past(i_portd_pin[6], 3))
    else $error("capture input wrong");
endmodule // pcd_alt_override_asserts
bind pcd_alt_override pcd_alt_override_asserts u_pcd_alt_override_asserts (.*);
`default_nettype wire

// ### test/pcd_pin_model.sv
// Purpose: package pins of one 8-bit port and the far-side drivers
// Assumes: far side drives only where the bench enables it
// Notes:   a pin nobody drives or pulls toggles every cycle
`timescale 1ns/100ps
`default_nettype none
module pcd_pin_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe_n,
  input  wire logic [7:0] i_pullup,
  input  wire logic [7:0] i_ext_en,
  input  wire logic [7:0] i_ext_val,
  output logic      [7:0] o_level
);
  logic       float_ff = 1'b0;
  logic [7:0] drv;
  always @(posedge i_clk) begin
    float_ff <= ~float_ff;
  end
  assign drv = ~i_oe_n;
  assign o_level = (drv & i_out & (~i_ext_en | i_ext_val)) | (~drv & i_ext_en & i_ext_val)
                 | (~drv & ~i_ext_en & (i_pullup | {8{float_ff}}));
endmodule // pcd_pin_model
`default_nettype wire

// ### test/testbench.sv
// Purpose: self-checking bench for the port C/D override block
// Assumes: pins resolved by pcd_pin_model, checker bound to the design
// Notes:   inputs change by NBA at the rising edge, checks at the falling edge
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic       i_clk = 1'b0, i_reset = 1'b1, i_global_pullup_disable = 1'b0, i_async_timer_clock_sel = 1'b0;
  logic       i_test_access_enable = 1'b0, i_instr_reg_shifting = 1'b0, i_data_reg_shifting = 1'b0;
  logic       i_test_data_out = 1'b0, i_two_wire_enable = 1'b0, i_two_wire_sda_out = 1'b0;
  logic       i_two_wire_scl_out = 1'b0, i_timer2_compare_en = 1'b0, i_timer2_compare_out = 1'b0;
  logic       i_timer1_compare_a_en = 1'b0, i_timer1_compare_a_out = 1'b0, i_timer1_compare_b_en = 1'b0;
  logic       i_timer1_compare_b_out = 1'b0, i_ext_irq_zero_en = 1'b0, i_ext_irq_one_en = 1'b0;
  logic       i_serial_tx_enable = 1'b0, i_serial_tx_data = 1'b0, i_serial_rx_enable = 1'b0;
  logic [7:0] i_portc_data = 8'h00, i_portc_dir = 8'h00, i_portd_data = 8'h00, i_portd_dir = 8'h00;
  logic [7:0] ext_c_en = 8'h00, ext_c_val = 8'h00, ext_d_en = 8'h00, ext_d_val = 8'h00;
  wire  [7:0] o_portc_pin_out, o_portc_pin_oe_n, o_portc_pullup, o_portd_pin_out, o_portd_pin_oe_n;
  wire  [7:0] o_portd_pullup, o_portc_in, o_portd_in, i_portc_pin, i_portd_pin;
  wire        o_two_wire_slew_limit, o_timer_osc_active, o_test_data_in, o_test_mode_sel, o_test_clock;
  wire        o_two_wire_sda_in, o_two_wire_scl_in, o_timer1_capture_in, o_ext_irq_zero_in;
  wire        o_ext_irq_one_in, o_serial_rx_data;
  int         mismatches = 0, checked = 0;
  pcd_alt_override u_pcd_alt_override (.*);
  pcd_pin_model u_pcd_pin_model_c (.i_clk(i_clk), .i_out(o_portc_pin_out), .i_oe_n(o_portc_pin_oe_n),
    .i_pullup(o_portc_pullup), .i_ext_en(ext_c_en), .i_ext_val(ext_c_val), .o_level(i_portc_pin));
  pcd_pin_model u_pcd_pin_model_d (.i_clk(i_clk), .i_out(o_portd_pin_out), .i_oe_n(o_portd_pin_oe_n),
    .i_pullup(o_portd_pullup), .i_ext_en(ext_d_en), .i_ext_val(ext_d_val), .o_level(i_portd_pin));
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic setp(input logic [7:0] cd, input logic [7:0] cr, input logic [7:0] dd, input logic [7:0] dr);
    @(posedge i_clk);
    i_portc_data <= cd;
    i_portc_dir <= cr;
    i_portd_data <= dd;
    i_portd_dir <= dr;
  endtask
  task automatic t_plain;
    setp(8'h5A, 8'h0F, 8'h5A, 8'h0F);
    ext_c_en <= 8'hF0;
    ext_c_val <= 8'hA5;
    ext_d_en <= 8'hF0;
    ext_d_val <= 8'hA5;
    w(5);
    chk(o_portc_pin_oe_n, 8'hF0);
    chk(o_portc_pin_out & 8'h0F, 8'h0A);
    chk(o_portc_pullup, 8'h50);
    chk(o_portc_in, 8'hAA);
    chk(o_portd_pullup, 8'h50);
    chk(o_portd_in, 8'hAA);
    @(posedge i_clk);
    i_global_pullup_disable <= 1'b1;
    w(2);
    chk(o_portc_pullup | o_portd_pullup, 8'h00);
    @(posedge i_clk);
    i_global_pullup_disable <= 1'b0;
    $display("test plain done");
  endtask
  task automatic t_osc;
    setp(8'hC0, 8'h80, 8'h00, 8'h00);
    ext_c_en <= 8'hC0;
    ext_c_val <= 8'hC0;
    i_async_timer_clock_sel <= 1'b1;
    w(5);
    chk(o_portc_pin_oe_n & 8'hC0, 8'hC0);
    chk(o_portc_pullup & 8'hC0, 8'h00);
    chk(o_portc_in & 8'hC0, 8'h00);
    chk(o_timer_osc_active, 8'h01);
    @(posedge i_clk);
    i_async_timer_clock_sel <= 1'b0;
    $display("test osc done");
  endtask
  task automatic t_test;
    setp(8'hFF, 8'h2C, 8'h00, 8'h00);
    ext_c_en <= 8'h2C;
    ext_c_val <= 8'h24;
    i_test_access_enable <= 1'b1;
    i_instr_reg_shifting <= 1'b1;
    i_test_data_out <= 1'b1;
    w(5);
    chk(o_portc_pin_oe_n & 8'h3C, 8'h2C);
    chk(o_portc_pin_out & 8'h10, 8'h10);
    chk(o_portc_pullup & 8'h3C, 8'h2C);
    chk(o_portc_in & 8'h2C, 8'h00);
    chk({o_test_data_in, o_test_mode_sel, o_test_clock}, 8'h05);
    @(posedge i_clk);
    i_instr_reg_shifting <= 1'b0;
    i_data_reg_shifting <= 1'b1;
    i_test_data_out <= 1'b0;
    ext_c_val <= 8'h08;
    w(5);
    chk(o_portc_pin_oe_n & 8'h10, 8'h00);
    chk(o_portc_pin_out & 8'h10, 8'h00);
    chk({o_test_data_in, o_test_mode_sel, o_test_clock}, 8'h02);
    @(posedge i_clk);
    i_data_reg_shifting <= 1'b0;
    w(2);
    chk(o_portc_pin_oe_n & 8'h10, 8'h10);
    @(posedge i_clk);
    i_reset <= 1'b1;
    w(2);
    chk(o_portc_pullup & 8'h2C, 8'h2C);
    @(posedge i_clk);
    i_reset <= 1'b0;
    i_test_access_enable <= 1'b0;
    w(3);
    $display("test access done");
  endtask
  task automatic t_twi;
    setp(8'h03, 8'h03, 8'h00, 8'h00);
    ext_c_en <= 8'h01;
    ext_c_val <= 8'h01;
    i_two_wire_enable <= 1'b1;
    i_two_wire_sda_out <= 1'b1;
    w(3);
    chk(o_portc_pin_oe_n & 8'h03, 8'h01);
    chk(o_portc_pin_out & 8'h03, 8'h00);
    chk(o_portc_pullup & 8'h03, 8'h03);
    chk(o_two_wire_slew_limit, 8'h01);
    w(4);
    chk({o_two_wire_sda_in, o_two_wire_scl_in}, 8'h01);
    @(posedge i_clk);
    ext_c_val <= 8'h00;
    @(posedge i_clk);
    ext_c_val <= 8'h01;
    repeat (8) begin
      w(0);
      chk(o_two_wire_scl_in, 8'h01);
    end
    @(posedge i_clk);
    ext_c_val <= 8'h00;
    i_global_pullup_disable <= 1'b1;
    i_two_wire_sda_out <= 1'b0;
    i_two_wire_scl_out <= 1'b1;
    w(7);
    chk(o_portc_pin_oe_n & 8'h03, 8'h02);
    chk(o_two_wire_scl_in, 8'h00);
    chk(o_portc_pullup & 8'h03, 8'h00);
    @(posedge i_clk);
    i_two_wire_enable <= 1'b0;
    i_global_pullup_disable <= 1'b0;
    ext_c_en <= 8'h00;
    $display("test two-wire done");
  endtask
  task automatic t_timer;
    setp(8'h00, 8'h00, 8'h40, 8'hB0);
    ext_d_en <= 8'h40;
    ext_d_val <= 8'h40;
    {i_timer2_compare_en, i_timer1_compare_a_en, i_timer1_compare_b_en} <= 3'h7;
    {i_timer2_compare_out, i_timer1_compare_a_out, i_timer1_compare_b_out} <= 3'h7;
    w(5);
    chk(o_portd_pin_oe_n & 8'hF0, 8'h40);
    chk(o_portd_pin_out & 8'hB0, 8'hB0);
    chk(o_portd_pullup & 8'h40, 8'h40);
    chk(o_timer1_capture_in, 8'h01);
    @(posedge i_clk);
    {i_timer2_compare_out, i_timer1_compare_a_out, i_timer1_compare_b_out} <= 3'h0;
    ext_d_val <= 8'h00;
    w(5);
    chk(o_portd_pin_out & 8'hB0, 8'h00);
    chk(o_timer1_capture_in, 8'h00);
    @(posedge i_clk);
    {i_timer2_compare_en, i_timer1_compare_a_en, i_timer1_compare_b_en} <= 3'h0;
    $display("test timer done");
  endtask
  task automatic t_irq_serial;
    setp(8'h00, 8'h00, 8'h01, 8'h01);
    ext_d_en <= 8'h0D;
    ext_d_val <= 8'h08;
    {i_ext_irq_zero_en, i_ext_irq_one_en, i_serial_tx_enable, i_serial_rx_enable} <= 4'hF;
    i_serial_tx_data <= 1'b1;
    w(5);
    chk({o_ext_irq_one_in, o_ext_irq_zero_in}, 8'h02);
    chk(o_portd_pin_oe_n & 8'h03, 8'h01);
    chk(o_portd_pin_out & 8'h02, 8'h02);
    chk(o_portd_pullup & 8'h03, 8'h01);
    chk(o_serial_rx_data, 8'h00);
    setp(8'h00, 8'h00, 8'h05, 8'h0D);
    ext_d_en <= 8'h01;
    ext_d_val <= 8'h01;
    i_serial_tx_data <= 1'b0;
    w(5);
    chk({o_ext_irq_one_in, o_ext_irq_zero_in}, 8'h01);
    chk(o_portd_pin_out & 8'h02, 8'h00);
    chk(o_serial_rx_data, 8'h01);
    @(posedge i_clk);
    {i_ext_irq_zero_en, i_ext_irq_one_en, i_serial_tx_enable, i_serial_rx_enable} <= 4'h0;
    $display("test irq and serial done");
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    w(3);
    t_plain;
    t_osc;
    t_test;
    t_twi;
    t_timer;
    t_irq_serial;
    stop_test;
  end
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end
endmodule // testbench
`default_nettype wire
